/* File: logic/irxcm_consts.vh */
// Constants for the isochronous receive context match filter
`ifndef IRXCM_CONSTS_VH
`define IRXCM_CONSTS_VH
`define IRXCM_ADDR_W 16
`define IRXCM_MATCH_BASE 16'h410c
`define IRXCM_MATCH_STRIDE 16'h0020
`define IRXCM_CTRL_ADDR 16'h4200
`define IRXCM_STATUS_ADDR 16'h4204
`define IRXCM_COUNT_BASE 16'h4210
`define IRXCM_COUNT_STRIDE 16'h0004
`define IRXCM_NUM_CTX 4
`define IRXCM_MATCH_WMASK 32'hf7ffff7f
`define IRXCM_MATCH_RESET 32'h00000000
`define IRXCM_CTRL_RESET 32'h00000000
`define IRXCM_ACCEPT_TAG_THREE_BIT 31
`define IRXCM_ACCEPT_TAG_TWO_BIT 30
`define IRXCM_ACCEPT_TAG_ONE_BIT 29
`define IRXCM_ACCEPT_TAG_ZERO_BIT 28
`define IRXCM_CYC_HI 26
`define IRXCM_CYC_LO 12
`define IRXCM_SYNC_HI 11
`define IRXCM_SYNC_LO 8
`define IRXCM_T1SYNC_BIT 6
`define IRXCM_CHAN_HI 5
`define IRXCM_CHAN_LO 0
`define IRXCM_CTRL_CME_LO 0
`define IRXCM_CTRL_RUN_LO 8
`define IRXCM_STAT_START_LO 0
`define IRXCM_STAT_HIT_LO 8
`define IRXCM_WAIT_SYNC 2'h3
`define IRXCM_TAG_ONE 2'h1
`define IRXCM_COUNT_W 16
`endif

/* File: logic/irxcm_filter.v */
// Per-context acceptance decision for one isochronous receive context
`timescale 1ns/1ps
`include "irxcm_consts.vh"
module irxcm_filter (
  input wire [31:0] match_reg,
  input wire started,
  input wire [1:0] wait_field,
  input wire [5:0] pkt_channel,
  input wire [1:0] pkt_tag,
  input wire [3:0] pkt_sync,
  output reg accept,
  output reg sync_ok
);
  reg chan_ok;
  reg tag_ok;
  reg need_sync;
  always @* begin
    chan_ok = (pkt_channel == match_reg[`IRXCM_CHAN_HI:`IRXCM_CHAN_LO]); // [RL9]
    // Tag enable bit chosen by the packet tag: 11b->31, 10b->30, 01b->29, 00b->28
    case (pkt_tag)
      2'h3: tag_ok = match_reg[`IRXCM_ACCEPT_TAG_THREE_BIT]; // [RL1]
      2'h2: tag_ok = match_reg[`IRXCM_ACCEPT_TAG_TWO_BIT]; // [RL1] [RL7]
      2'h1: tag_ok = match_reg[`IRXCM_ACCEPT_TAG_ONE_BIT] &
                     (~match_reg[`IRXCM_T1SYNC_BIT] | (pkt_sync[3:2] == 2'h0)); // [RL6] [RL8]
      default: tag_ok = match_reg[`IRXCM_ACCEPT_TAG_ZERO_BIT]; // [RL1] [RL7]
    endcase
    need_sync = (wait_field == `IRXCM_WAIT_SYNC);
    sync_ok = ~need_sync | (pkt_sync == match_reg[`IRXCM_SYNC_HI:`IRXCM_SYNC_LO]); // [RL5]
    accept = chan_ok & tag_ok & sync_ok & started; // [RL12]
  end
endmodule // irxcm_filter

/* File: logic/irxcm_top.v */
// Isochronous receive context match filter: registers, start logic and packet acceptance
//
// Summary of operation
// [RL1] Tag-enable bits 31..28 let tags 11b, 10b, 01b and 00b through, one bit per tag.
// [RL2] Bits 27 and 7 of each match register always read as zero.
// [RL3] The cycle-match field holds two low seconds bits followed by the 13-bit cycle count.
// [RL4] With start-on-cycle on, a context starts only when the timer equals the cycle-match field.
// [RL5] The sync field is compared with every packet's sync when the descriptor wait field is 11b.
// [RL6] With the tag-one sync restriction and tag 01b enabled, tag 01b needs sync bits 3..2 of 00b.
// [RL7] Under the tag-one sync restriction other tags pass on their own enable bit only.
// [RL8] With the tag-one sync restriction clear, only the four tag-enable bits decide.
// [RL9] Only packets whose channel equals bits 5..0 are accepted.
// [RL10] Four match registers exist, one per context, 32 bytes apart.
// [RL11] Software starts a context by setting its run bit before packets are taken.
// [RL12] A packet is accepted only on channel match, tag and sync pass, and a met start condition.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "irxcm_consts.vh"
module irxcm_top #(
  parameter NUM_CTX = `IRXCM_NUM_CTX,
  parameter COUNT_W = `IRXCM_COUNT_W
) (
  input wire clk,
  input wire rst_b,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [6:0] timer_seconds_count,
  input wire [12:0] timer_cycle_count,
  input wire [2*NUM_CTX-1:0] wait_field,
  input wire pkt_valid,
  input wire [5:0] pkt_channel,
  input wire [1:0] pkt_tag,
  input wire [3:0] pkt_sync,
  output reg [NUM_CTX-1:0] pkt_accept,
  output reg [NUM_CTX-1:0] sync_hit,
  output reg [NUM_CTX-1:0] ctx_started
);
  reg [31:0] match_reg [0:NUM_CTX-1];
  reg [NUM_CTX-1:0] start_on_cycle_enable;
  reg [NUM_CTX-1:0] run;
  reg [COUNT_W-1:0] accept_count [0:NUM_CTX-1];
  reg [31:0] next_rdata;
  wire [NUM_CTX-1:0] accept_now;
  wire [NUM_CTX-1:0] sync_ok_now;
  wire [14:0] timer_now;
  wire match_hit;
  wire [1:0] match_idx;
  wire count_hit;
  wire [1:0] count_idx;
  // Sized copies so the decode can slice them; the bare macros would mix widths
  localparam [15:0] MATCH_BASE = `IRXCM_MATCH_BASE;
  localparam [15:0] COUNT_BASE = `IRXCM_COUNT_BASE;

  // Low two seconds bits concatenated with the cycle count, same layout as the field
  assign timer_now = {timer_seconds_count[1:0], timer_cycle_count}; // [RL3]

  // Match registers sit at base + 32*n: low five bits fixed, bits 6..5 pick the context
  assign match_hit = (reg_addr[15:7] == MATCH_BASE[15:7]) &&
                     (reg_addr[4:0] == MATCH_BASE[4:0]) &&
                     ({14'h0000, reg_addr[6:5]} < NUM_CTX); // [RL10]
  assign match_idx = reg_addr[6:5];
  assign count_hit = (reg_addr[15:4] == COUNT_BASE[15:4]) &&
                     (reg_addr[1:0] == 2'h0) &&
                     ({14'h0000, reg_addr[3:2]} < NUM_CTX);
  assign count_idx = reg_addr[3:2];

  genvar g;
  generate
    for (g = 0; g < NUM_CTX; g = g + 1) begin : ctx
      irxcm_filter u_filter (
        .match_reg(match_reg[g]),
        .started(ctx_started[g]),
        .wait_field(wait_field[2*g+1:2*g]),
        .pkt_channel(pkt_channel),
        .pkt_tag(pkt_tag),
        .pkt_sync(pkt_sync),
        .accept(accept_now[g]),
        .sync_ok(sync_ok_now[g])
      );

      always @(posedge clk) begin
        if (!rst_b) begin
          match_reg[g] <= `IRXCM_MATCH_RESET;
        end else if (reg_wr && match_hit && match_idx == g) begin
          // Reserved bits are never stored, so they read back as zero
          match_reg[g] <= reg_wdata & `IRXCM_MATCH_WMASK; // [RL2]
        end
      end

      // Start condition: cleared while run is low, set once run is high and either
      // start-on-cycle is off or the timer reaches the programmed cycle
      always @(posedge clk) begin
        if (!rst_b) begin
          ctx_started[g] <= 1'b0;
        end else if (!run[g]) begin
          ctx_started[g] <= 1'b0; // [RL11]
        end else if (!ctx_started[g]) begin
          ctx_started[g] <= !start_on_cycle_enable[g] ||
                            (timer_now == match_reg[g][`IRXCM_CYC_HI:`IRXCM_CYC_LO]); // [RL4]
        end
      end

      always @(posedge clk) begin
        if (!rst_b) begin
          pkt_accept[g] <= 1'b0;
          sync_hit[g] <= 1'b0;
        end else begin
          pkt_accept[g] <= pkt_valid & accept_now[g]; // [RL12]
          // Sync hit only reported for packets on this context's channel while waiting
          sync_hit[g] <= pkt_valid && run[g] &&
                         (wait_field[2*g+1:2*g] == `IRXCM_WAIT_SYNC) &&
                         (pkt_channel == match_reg[g][`IRXCM_CHAN_HI:`IRXCM_CHAN_LO]) &&
                         sync_ok_now[g]; // [RL5]
        end
      end

      // Counter write clears it; a packet in the same cycle still counts, so none is lost
      always @(posedge clk) begin
        if (!rst_b) begin
          accept_count[g] <= {COUNT_W{1'b0}};
        end else if (pkt_valid && accept_now[g]) begin
          if (reg_wr && count_hit && count_idx == g) begin
            accept_count[g] <= {{(COUNT_W-1){1'b0}}, 1'b1};
          end else begin
            accept_count[g] <= accept_count[g] + {{(COUNT_W-1){1'b0}}, 1'b1};
          end
        end else if (reg_wr && count_hit && count_idx == g) begin
          accept_count[g] <= {COUNT_W{1'b0}};
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_b) begin
      start_on_cycle_enable <= {NUM_CTX{1'b0}};
      run <= {NUM_CTX{1'b0}};
    end else if (reg_wr && reg_addr == `IRXCM_CTRL_ADDR) begin
      start_on_cycle_enable <= reg_wdata[`IRXCM_CTRL_CME_LO+NUM_CTX-1:`IRXCM_CTRL_CME_LO];
      run <= reg_wdata[`IRXCM_CTRL_RUN_LO+NUM_CTX-1:`IRXCM_CTRL_RUN_LO]; // [RL11]
    end
  end

  // Read mux; unmapped addresses return zero so software never sees stale data
  always @* begin
    next_rdata = 32'h00000000;
    if (match_hit) begin
      next_rdata = match_reg[match_idx]; // [RL2]
    end else if (count_hit) begin
      next_rdata[COUNT_W-1:0] = accept_count[count_idx];
    end else if (reg_addr == `IRXCM_CTRL_ADDR) begin
      next_rdata[`IRXCM_CTRL_CME_LO+NUM_CTX-1:`IRXCM_CTRL_CME_LO] = start_on_cycle_enable;
      next_rdata[`IRXCM_CTRL_RUN_LO+NUM_CTX-1:`IRXCM_CTRL_RUN_LO] = run;
    end else if (reg_addr == `IRXCM_STATUS_ADDR) begin
      next_rdata[`IRXCM_STAT_START_LO+NUM_CTX-1:`IRXCM_STAT_START_LO] = ctx_started;
      next_rdata[`IRXCM_STAT_HIT_LO+NUM_CTX-1:`IRXCM_STAT_HIT_LO] = sync_hit;
    end
  end

  // Data only valid the cycle after the read strobe; held at zero otherwise
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // irxcm_top

/* File: tb/irxcm_chk.sv */
// Checker for context 0 of the receive match filter
`timescale 1ns/1ps
module irxcm_chk #(parameter NUM_CTX = 4) (
  input wire clk, input wire rst_b, input wire [15:0] reg_addr, input wire [31:0] reg_wdata,
  input wire reg_wr, input wire reg_rd, input wire [31:0] reg_rdata, input wire [6:0] timer_seconds_count,
  input wire [12:0] timer_cycle_count, input wire [2*NUM_CTX-1:0] wait_field, input wire pkt_valid,
  input wire [5:0] pkt_channel, input wire [1:0] pkt_tag, input wire [3:0] pkt_sync,
  input wire [NUM_CTX-1:0] pkt_accept, input wire [NUM_CTX-1:0] sync_hit, input wire [NUM_CTX-1:0] ctx_started
);
  reg [31:0] m0;
  reg [1:0] c0;
  wire ok0 = pkt_valid && ctx_started[0] && pkt_channel == m0[5:0] && m0[28 + pkt_tag]
    && !(pkt_tag == 2'h1 && m0[6] && pkt_sync[3:2] != 2'h0) && (wait_field[1:0] != 2'h3 || pkt_sync == m0[11:8]);
  // Shadow of match 0 and of run and start-on-cycle 0
  always @(posedge clk) begin
    if (!rst_b) begin
      m0 <= 32'h0;
      c0 <= 2'h0;
    end else if (reg_wr && reg_addr == 16'h410c) begin
      m0 <= reg_wdata & 32'hf7ffff7f;
    end else if (reg_wr && reg_addr == 16'h4200) begin
      c0 <= {reg_wdata[8], reg_wdata[0]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_match_readback: assert property ($past(reg_rd && reg_addr == 16'h410c) |-> reg_rdata == m0)
    else $error("match readback");
  a_rsvd_zero: assert property ($past(reg_rd && reg_addr[15:8] == 8'h41 && reg_addr[4:0] == 5'h0c)
    |-> reg_rdata[27] == 1'b0 && reg_rdata[7] == 1'b0) else $error("reserved bit set");
  a_accept_due: assert property ($past(ok0) |-> pkt_accept[0])
    else $error("packet dropped");
  a_accept_cause: assert property (pkt_accept[0] |-> $past(ok0))
    else $error("packet wrongly taken");
  a_sync_hit: assert property (sync_hit[0] == $past(pkt_valid && c0[1] && wait_field[1:0] == 2'h3
    && pkt_channel == m0[5:0] && pkt_sync == m0[11:8])) else $error("sync hit");
  a_free_start: assert property ($rose(c0[1]) && !c0[0] |=> ctx_started[0]) else $error("no start");
  a_cycle_start: assert property ($rose(ctx_started[0]) && c0[0]
    |-> $past({timer_seconds_count[1:0], timer_cycle_count}) == m0[26:12]) else $error("start off cycle");
  a_run_stop: assert property (!c0[1] |=> !ctx_started[0]) else $error("started without run");
endmodule // irxcm_chk
bind irxcm_top irxcm_chk #(.NUM_CTX(NUM_CTX)) u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .timer_seconds_count, .timer_cycle_count, .wait_field, .pkt_valid, .pkt_channel, .pkt_tag,
  .pkt_sync, .pkt_accept, .sync_hit, .ctx_started);

/* File: tb/irxcm_link_model.sv */
// Link receiver and cycle timer model
`timescale 1ns/1ps
module irxcm_link_model (
  input wire clk, input wire rst_b, output reg [6:0] timer_seconds_count, output reg [12:0] timer_cycle_count,
  output reg pkt_valid, output reg [5:0] pkt_channel, output reg [1:0] pkt_tag, output reg [3:0] pkt_sync
);
  initial begin
    {timer_seconds_count, timer_cycle_count, pkt_valid, pkt_channel, pkt_tag, pkt_sync} = 33'h0;
  end
  // Plain binary count; the cycle field wrap is not modelled
  always @(posedge clk) begin
    if (!rst_b) begin
      {timer_seconds_count, timer_cycle_count} <= 20'h0;
    end else begin
      {timer_seconds_count, timer_cycle_count} <= {timer_seconds_count, timer_cycle_count} + 20'h1;
    end
  end
  // Header flips after the pulse so a stale header never looks valid
  task send(input [5:0] ch, input [1:0] tg, input [3:0] sy);
    begin
      @(posedge clk);
      pkt_valid <= 1'b1;
      {pkt_channel, pkt_tag, pkt_sync} <= {ch, tg, sy};
      @(posedge clk);
      pkt_valid <= 1'b0;
      {pkt_channel, pkt_tag, pkt_sync} <= ~{ch, tg, sy};
    end
  endtask
endmodule // irxcm_link_model

/* File: tb/irxcm_top_bench.sv */
// Bench: registers, packet filters, sync wait and start on cycle
`timescale 1ns/1ps
module irxcm_top_bench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [15:0] ra = 16'h0;
  reg [31:0] wd = 32'h0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg [7:0] wf = 8'h0;
  wire [31:0] rdat;
  wire [6:0] sec;
  wire [12:0] cyc;
  wire pv;
  wire [5:0] ch;
  wire [1:0] tg;
  wire [3:0] sy;
  wire [3:0] acc;
  wire [3:0] hit;
  wire [3:0] st;
  integer num_errors = 0;
  integer num_checks = 0;
  integer i;
  irxcm_top u_irxcm_top (.clk(clk), .rst_b(rst_b), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdat), .timer_seconds_count(sec), .timer_cycle_count(cyc), .wait_field(wf), .pkt_valid(pv),
    .pkt_channel(ch), .pkt_tag(tg), .pkt_sync(sy), .pkt_accept(acc), .sync_hit(hit), .ctx_started(st));
  irxcm_link_model u_irxcm_link_model (.clk(clk), .rst_b(rst_b), .timer_seconds_count(sec),
    .timer_cycle_count(cyc), .pkt_valid(pv), .pkt_channel(ch), .pkt_tag(tg), .pkt_sync(sy));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {wr_s, ra, wd} <= {1'b1, a, d};
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      @(posedge clk);
      {rd_s, ra} <= {1'b1, a};
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdat, e);
    end
  endtask
  // Sends one header; only context 0 ever has its run bit set, the others must stay quiet
  task pk(input [5:0] c, input [1:0] t, input [3:0] s, input [1:0] e);
    begin
      u_irxcm_link_model.send(c, t, s);
      #1 chk({hit, acc}, {3'h0, e[1], 3'h0, e[0]});
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wr(16'h410c, 32'hffffffff);
    rd(16'h410c, 32'hf7ffff7f);
    wr(16'h412c, 32'h00001234);
    rd(16'h412c, 32'h00001234);
    rd(16'h416c, 32'h0);
    rd(16'h4110, 32'h0);
    $display("registers done");
    wr(16'h410c, 32'hf0000005);
    pk(6'h5, 2'h0, 4'h0, 2'h0);
    wr(16'h4200, 32'h00000100);
    for (i = 0; i < 4; i = i + 1)
      pk(6'h5, i[1:0], 4'hf, 2'h1);
    pk(6'h6, 2'h3, 4'h0, 2'h0);
    wr(16'h410c, 32'h20000045);
    pk(6'h5, 2'h1, 4'h3, 2'h1);
    pk(6'h5, 2'h1, 4'h4, 2'h0);
    pk(6'h5, 2'h0, 4'h0, 2'h0);
    wr(16'h410c, 32'h50000045);
    pk(6'h5, 2'h2, 4'hc, 2'h1);
    pk(6'h5, 2'h1, 4'h0, 2'h0);
    wr(16'h410c, 32'hf0000a05);
    wf <= 8'h03;
    pk(6'h5, 2'h2, 4'ha, 2'h3);
    pk(6'h5, 2'h2, 4'h5, 2'h0);
    wf <= 8'h00;
    $display("filters done");
    wr(16'h4200, 32'h0);
    rd(16'h4204, 32'h00000000);
    wr(16'h410c, 32'hf2010005);
    wr(16'h4200, 32'h00000101);
    rd(16'h4200, 32'h00000101);
    pk(6'h5, 2'h0, 4'h0, 2'h0);
    i = 0;
    while (st[0] !== 1'b1 && i < 10000) begin
      @(posedge clk);
      #1 i = i + 1;
    end
    chk({sec[1:0], cyc}, 32'h2011);
    pk(6'h5, 2'h0, 4'h0, 2'h1);
    rd(16'h4204, 32'h00000001);
    // Eight packets of context 0 passed every filter since reset
    rd(16'h4210, 32'h00000008);
    wr(16'h4210, 32'h0);
    rd(16'h4210, 32'h0);
    $display("start on cycle done");
    conclude;
  end
endmodule // irxcm_top_bench
